// ==== logic/rsq_pkg.sv ====
// package: timing constants and enumerations for the reset/suspend sequencer
package rsq_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS    = 10;
  localparam int unsigned CPU_RST_DELAY_MS = 1;
  localparam int unsigned CPU_RST_DELAY_CYC =
    (CPU_RST_DELAY_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned STRAP_HOLD_CYC   = 4;
  localparam int unsigned BREQ_LEAD_CYC    = 2;
  localparam int unsigned BREQ_TAIL_CYC    = 2;
  localparam int unsigned STRAP_FLOAT_CYC  = 4;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic        CPU_RST_ACTIVE   = 1'h1;
  localparam logic [1:0]  STRAP_RST_VAL    = 2'h0;

  typedef enum logic [1:0] {
    RSQ_WAKE_COLD,
    RSQ_WAKE_STR,
    RSQ_WAKE_POS
  } rsq_wake_t;
endpackage : rsq_pkg

// ==== logic/rsq_sync.sv ====
// three-stage synchroniser that reports a change once stages two and three agree
module rsq_sync #(
  parameter logic RST_VAL = 1'h0
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_b,
  // data
  input  wire logic async_in,
  output logic      sync_out
);
  logic s1_ff, s2_ff, s3_ff, out_ff;
  logic nxt_out;

  always_comb begin
    nxt_out = out_ff;
    if (s2_ff == s3_ff) begin
      nxt_out = s3_ff;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      s1_ff  <= RST_VAL;
      s2_ff  <= RST_VAL;
      s3_ff  <= RST_VAL;
      out_ff <= RST_VAL;
    end else begin
      s1_ff  <= async_in;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      out_ff <= nxt_out;
    end
  end

  assign sync_out = out_ff;
endmodule : rsq_sync

// ==== logic/rsq_sequencer.sv ====
// reset and suspend pin sequencer for the host-side controller
module rsq_sequencer #(
  parameter int unsigned CPU_RST_DELAY = rsq_pkg::CPU_RST_DELAY_CYC,
  parameter int unsigned NUM_RGPIO     = 6
) (
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst_b,
  // reset and suspend pins
  input  wire logic                 pci_bus_reset_b,
  input  wire logic                 resume_well_reset_b,
  input  wire logic                 suspend_status_out_b,
  input  wire logic                 suspend_to_ram,
  input  wire logic                 pos_cpu_reset_en,
  input  wire logic                 suspend_active,
  output logic                      cpu_reset_out_b,
  // strap sources
  input  wire logic [1:0]           mem_addr_lines,
  input  wire logic [3:0]           bus_ratio,
  // processor strap pins
  output logic                      queue_depth_strap_pin_o,
  output logic                      queue_depth_strap_pin_oe,
  output logic                      quick_start_strap_pin_o,
  output logic                      quick_start_strap_pin_oe,
  output logic                      bus_request_zero_b_o,
  output logic                      bus_request_zero_oe,
  // bus ratio pins
  output logic                      addr_bit20_mask_b,
  output logic                      ignore_numeric_error_b,
  output logic                      cpu_nmi,
  output logic                      cpu_int_request,
  output logic                      ratio_drive_en,
  // output enable control
  input  wire logic                 func_out_en,
  output logic                      reg_out_en,
  output logic                      comb_out_en,
  output logic                      strap_float,
  output logic                      host_out_en,
  output logic                      host_in_isolate,
  // resume-well gpio
  input  wire logic [NUM_RGPIO-1:0] rgpio_sel_gpio,
  output logic [NUM_RGPIO-1:0]      rgpio_gpio_mode,
  // sdram control
  output logic                      sdram_cke,
  output logic                      sdram_ras_b,
  output logic                      sdram_cas_b
);
  // ---------------------------------------------------------------
  // synchronisers
  // ---------------------------------------------------------------
  logic pci_rst_b_s, rsm_rst_b_s, suspend_status_out_b_s, susp_s, str_s;

  rsq_sync #(.RST_VAL(1'h0)) u_pci (.sys_clk(sys_clk), .rst_b(rst_b),
    .async_in(pci_bus_reset_b), .sync_out(pci_rst_b_s));
  rsq_sync #(.RST_VAL(1'h0)) u_rsm (.sys_clk(sys_clk), .rst_b(rst_b),
    .async_in(resume_well_reset_b), .sync_out(rsm_rst_b_s));
  rsq_sync #(.RST_VAL(1'h0)) u_sus (.sys_clk(sys_clk), .rst_b(rst_b),
    .async_in(suspend_status_out_b), .sync_out(suspend_status_out_b_s));
  rsq_sync #(.RST_VAL(1'h0)) u_spd (.sys_clk(sys_clk), .rst_b(rst_b),
    .async_in(suspend_active), .sync_out(susp_s));
  rsq_sync #(.RST_VAL(1'h0)) u_str (.sys_clk(sys_clk), .rst_b(rst_b),
    .async_in(suspend_to_ram), .sync_out(str_s));

  // ---------------------------------------------------------------
  // cpu reset timing
  // ---------------------------------------------------------------
  localparam int unsigned CW = $clog2(CPU_RST_DELAY + 1);
  localparam logic [CW-1:0] DLY = CW'(CPU_RST_DELAY);
  localparam logic [CW-1:0] LEAD = CW'(rsq_pkg::BREQ_LEAD_CYC);

  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic          cpu_rst_ff, nxt_cpu_rst;
  logic          arm_ff, nxt_arm;
  logic          sus_prev_ff, pci_prev_ff;
  logic          pos_wake_ff, nxt_pos_wake;
  logic [2:0]    post_ff, nxt_post;
  logic          breq_ff, nxt_breq;

  always_comb begin
    nxt_cnt      = cnt_ff;
    nxt_cpu_rst  = cpu_rst_ff;
    nxt_arm      = arm_ff;
    nxt_pos_wake = pos_wake_ff;
    nxt_post     = post_ff;
    nxt_breq     = 1'h0;
    // pos resume without a pci reset: timing starts at status release
    if (susp_s && pci_rst_b_s && pos_cpu_reset_en && !str_s) begin
      nxt_pos_wake = 1'h1;
      nxt_cpu_rst  = rsq_pkg::CPU_RST_ACTIVE;
    end
    if (!pci_rst_b_s) begin
      nxt_cpu_rst = rsq_pkg::CPU_RST_ACTIVE;
      nxt_arm     = 1'h0;
      nxt_cnt     = '0;
      nxt_pos_wake = 1'h0;
    end else if (!pci_prev_ff) begin
      nxt_arm = 1'h1;
      nxt_cnt = DLY;
    end else if (pos_wake_ff && suspend_status_out_b_s && !sus_prev_ff) begin
      nxt_arm      = 1'h1;
      nxt_cnt      = DLY;
      nxt_pos_wake = 1'h0;
    end else if (arm_ff && !pos_wake_ff) begin
      if (cnt_ff <= CW'(1)) begin
        nxt_cpu_rst = 1'h0;
        nxt_arm     = 1'h0;
        nxt_post    = 3'(rsq_pkg::STRAP_HOLD_CYC);
      end else begin
        nxt_cnt = cnt_ff - CW'(1);
      end
      // bus request goes low two clocks before release
      nxt_breq = (cnt_ff <= LEAD + CW'(1));
    end
    if (post_ff != 3'h0 && !nxt_cpu_rst) begin
      nxt_post = post_ff - 3'h1;
      // the release clock already carries the first tail clock
      if (post_ff > 3'(rsq_pkg::STRAP_HOLD_CYC - rsq_pkg::BREQ_TAIL_CYC + 1))
      begin
        nxt_breq = 1'h1;
      end
    end
    if (!pci_rst_b_s || susp_s) begin
      nxt_breq = 1'h0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      cnt_ff      <= '0;
      cpu_rst_ff  <= rsq_pkg::CPU_RST_ACTIVE;
      arm_ff      <= 1'h0;
      sus_prev_ff <= 1'h0;
      pci_prev_ff <= 1'h0;
      pos_wake_ff <= 1'h0;
      post_ff     <= 3'h0;
      breq_ff     <= 1'h0;
    end else begin
      cnt_ff      <= nxt_cnt;
      cpu_rst_ff  <= nxt_cpu_rst;
      arm_ff      <= nxt_arm;
      sus_prev_ff <= suspend_status_out_b_s;
      pci_prev_ff <= pci_rst_b_s;
      pos_wake_ff <= nxt_pos_wake;
      post_ff     <= nxt_post;
      breq_ff     <= nxt_breq;
    end
  end

  // ---------------------------------------------------------------
  // pin drive
  // ---------------------------------------------------------------
  logic [1:0] strap_ff, nxt_strap;
  logic       float_ff, nxt_float;
  logic [3:0] ratio_ff, nxt_ratio;
  logic [2:0] fl_ff, nxt_fl;
  logic       oe_ff, nxt_oe;
  logic       sr_ff, nxt_sr;
  logic [NUM_RGPIO-1:0] rg_ff, nxt_rg;

  always_comb begin
    nxt_strap = cpu_rst_ff ? mem_addr_lines : strap_ff;
    nxt_ratio = bus_ratio;
    nxt_oe    = pci_rst_b_s && func_out_en;
    nxt_fl    = fl_ff;
    if (!pci_rst_b_s || cpu_rst_ff) begin
      nxt_fl = 3'(rsq_pkg::STRAP_FLOAT_CYC);
    end else if (fl_ff != 3'h0) begin
      nxt_fl = fl_ff - 3'h1;
    end
    nxt_float = (nxt_fl != 3'h0);
    // enter self refresh once per suspend, cke held low until exit
    nxt_sr = susp_s;
    nxt_rg = rg_ff;
    if (!rsm_rst_b_s) begin
      nxt_rg = '0;
    end else if (pci_rst_b_s) begin
      nxt_rg = rgpio_sel_gpio;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      strap_ff <= rsq_pkg::STRAP_RST_VAL;
      ratio_ff <= 4'h0;
      oe_ff    <= 1'h0;
      fl_ff    <= 3'(rsq_pkg::STRAP_FLOAT_CYC);
      float_ff <= 1'h1;
      sr_ff    <= 1'h0;
      rg_ff    <= '0;
    end else begin
      strap_ff <= nxt_strap;
      ratio_ff <= nxt_ratio;
      oe_ff    <= nxt_oe;
      fl_ff    <= nxt_fl;
      float_ff <= nxt_float;
      sr_ff    <= nxt_sr;
      rg_ff    <= nxt_rg;
    end
  end

  // strap pins are host signals, so suspend takes them off the bus too
  logic strap_drv;
  assign strap_drv = (cpu_rst_ff || post_ff != 3'h0) && !susp_s;

  assign cpu_reset_out_b          = !cpu_rst_ff;
  assign queue_depth_strap_pin_o  = strap_ff[0];
  assign quick_start_strap_pin_o  = strap_ff[1];
  assign queue_depth_strap_pin_oe = strap_drv;
  assign quick_start_strap_pin_oe = strap_drv;
  assign bus_request_zero_b_o     = 1'h0;
  assign bus_request_zero_oe      = breq_ff;
  assign ratio_drive_en           = cpu_rst_ff && !susp_s;
  assign addr_bit20_mask_b        = ratio_ff[0];
  assign ignore_numeric_error_b   = ratio_ff[1];
  assign cpu_nmi                  = ratio_ff[2];
  assign cpu_int_request          = ratio_ff[3];
  assign reg_out_en               = oe_ff;
  // raw pin path: no synchroniser delay when pci reset drops this enable
  assign comb_out_en = pci_bus_reset_b && oe_ff;
  assign strap_float     = float_ff;
  assign host_out_en     = !susp_s;
  assign host_in_isolate = susp_s;
  assign rgpio_gpio_mode = rg_ff;
  assign sdram_cke   = !sr_ff;
  assign sdram_ras_b = !(susp_s && !sr_ff) && !sr_ff;
  assign sdram_cas_b = !(susp_s && !sr_ff) && !sr_ff;
endmodule : rsq_sequencer

// ==== testbench/rsq_seq_properties.sv ====
// checker: port-level timing of the reset and suspend sequencer
module rsq_seq_chk #(
  parameter int unsigned NUM_RGPIO = 6
) (
  // clock and reset
  input wire logic                 sys_clk,
  input wire logic                 rst_b,
  // reset and suspend inputs
  input wire logic                 pci_bus_reset_b,
  input wire logic                 resume_well_reset_b,
  input wire logic                 suspend_active,
  // watched outputs
  input wire logic                 cpu_reset_out_b,
  input wire logic                 queue_depth_strap_pin_oe,
  input wire logic                 bus_request_zero_b_o,
  input wire logic                 bus_request_zero_oe,
  input wire logic                 reg_out_en,
  input wire logic                 comb_out_en,
  input wire logic                 strap_float,
  input wire logic                 host_out_en,
  input wire logic                 host_in_isolate,
  input wire logic [NUM_RGPIO-1:0] rgpio_gpio_mode,
  input wire logic                 sdram_cke,
  input wire logic                 sdram_ras_b,
  input wire logic                 sdram_cas_b
);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  timeunit 1ns;
  timeprecision 1ps;
  // async inputs need about four clocks through the synchroniser
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence s_breq_tail;
    bus_request_zero_oe && !bus_request_zero_b_o ##1 bus_request_zero_oe
      ##1 !bus_request_zero_oe;
  endsequence
  sequence s_sr_enter;
    !sdram_ras_b && !sdram_cas_b && sdram_cke;
  endsequence
  sequence s_sr_hold;
    !sdram_ras_b && !sdram_cas_b && !sdram_cke;
  endsequence
  AST_CPU_HOLD: assert property (
    !pci_bus_reset_b [*6] |-> !cpu_reset_out_b)
    else $error("cpu reset released while pci reset held");
  AST_REG_EN: assert property (
    !pci_bus_reset_b [*6] |-> !reg_out_en)
    else $error("registered enable kept in pci reset");
  AST_COMB_EN: assert property (
    comb_out_en == (pci_bus_reset_b && reg_out_en))
    else $error("combinational enable wrong");
  AST_STRAP_HOLD: assert property (
    $rose(cpu_reset_out_b) |-> queue_depth_strap_pin_oe [*4])
    else $error("strap drive dropped too early");
  AST_BREQ: assert property (
    $rose(cpu_reset_out_b) |-> $past(bus_request_zero_oe) ##0 s_breq_tail)
    else $error("bus request not driven low around release");
  AST_GPIO_FN: assert property (
    !resume_well_reset_b [*6] |-> rgpio_gpio_mode == '0)
    else $error("gpio not functional in resume-well reset");
  AST_SUSP_ISO: assert property (
    suspend_active [*6] |-> !host_out_en && host_in_isolate)
    else $error("host interface not isolated in suspend");
  AST_SELF_REF: assert property (
    $fell(sdram_ras_b) |-> s_sr_enter ##1 s_sr_hold)
    else $error("self refresh command malformed");
  AST_STRAP_FLOAT: assert property (
    !pci_bus_reset_b [*6] |-> strap_float)
    else $error("straps not floated in pci reset");
endmodule : rsq_seq_chk

bind rsq_sequencer rsq_seq_chk #(.NUM_RGPIO(NUM_RGPIO)) u_chk (.*);

// ==== testbench/rsq_cpu_model.sv ====
// partner model: processor sampling straps and bus request at release
module rsq_cpu_model (
  // reset from the sequencer
  input  wire logic       cpu_rst_b,
  // strap and bus request pins
  input  wire logic       qd_o,
  input  wire logic       qd_oe,
  input  wire logic       qs_o,
  input  wire logic       qs_oe,
  input  wire logic       breq_o,
  input  wire logic       breq_oe,
  // what the processor latched
  output logic [1:0]      strap_seen,
  output logic            breq_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  // host bus lines are terminated high, so an undriven pin reads 1
  wire qd_line   = qd_oe ? qd_o : 1'h1;
  wire qs_line   = qs_oe ? qs_o : 1'h1;
  wire breq_line = breq_oe ? breq_o : 1'h1;
  // sample a little after the edge: strap enables settle in the same step
  always begin
    @(posedge cpu_rst_b);
    #1;
    strap_seen = {qs_line, qd_line};
    breq_seen  = breq_line;
  end
endmodule : rsq_cpu_model

// ==== testbench/testbench.sv ====
// testbench: random cold resets, suspends and gpio for the sequencer
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // short release delay keeps the run brief
  localparam int unsigned DLY = 20;
  logic sys_clk = 1'h0, rst_b = 1'h0, pci_bus_reset_b = 1'h0;
  logic resume_well_reset_b = 1'h0, suspend_status_out_b = 1'h1;
  logic suspend_to_ram = 1'h0, pos_cpu_reset_en = 1'h0;
  logic suspend_active = 1'h0, func_out_en = 1'h1;
  logic [1:0] mem_addr_lines = 2'h0, strap_seen;
  logic [3:0] bus_ratio = 4'h0;
  logic [5:0] rgpio_sel_gpio = 6'h0, rgpio_gpio_mode;
  logic [5:0] gpio_exp = 6'h0;
  logic cpu_reset_out_b, queue_depth_strap_pin_o, queue_depth_strap_pin_oe;
  logic quick_start_strap_pin_o, quick_start_strap_pin_oe, breq_seen;
  logic bus_request_zero_b_o, bus_request_zero_oe, addr_bit20_mask_b;
  logic ignore_numeric_error_b, cpu_nmi, cpu_int_request, ratio_drive_en;
  logic reg_out_en, comb_out_en, strap_float, host_out_en, host_in_isolate;
  logic sdram_cke, sdram_ras_b, sdram_cas_b;
  int seed = 63141, mismatches = 0, total_checks = 0, n;
  always #5 sys_clk = ~sys_clk;
  rsq_sequencer #(.CPU_RST_DELAY(DLY)) u_dut (.*);
  rsq_cpu_model u_cpu (.cpu_rst_b(cpu_reset_out_b),
    .qd_o(queue_depth_strap_pin_o), .qd_oe(queue_depth_strap_pin_oe),
    .qs_o(quick_start_strap_pin_o), .qs_oe(quick_start_strap_pin_oe),
    .breq_o(bus_request_zero_b_o), .breq_oe(bus_request_zero_oe),
    .strap_seen(strap_seen), .breq_seen(breq_seen));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done
  task automatic cyc(input int c);
    repeat (c) @(negedge sys_clk);
  endtask : cyc
  // bounded wait for release; n is the cycle count taken
  task automatic wait_rel;
    n = 0;
    while (cpu_reset_out_b !== 1'h1 && n < 200) begin
      cyc(1);
      n++;
    end
    if (n >= 200) begin
      mismatches++;
      test_done();
    end
  endtask : wait_rel
  task automatic cold;
    mem_addr_lines = 2'($random(seed));
    bus_ratio = 4'($random(seed));
    // gpio mode follows the request only while pci reset is released
    if (pci_bus_reset_b === 1'h1) gpio_exp = rgpio_sel_gpio;
    if (cpu_reset_out_b === 1'h1) check("reg_en", reg_out_en, 1'h1);
    pci_bus_reset_b = 1'h0;
    #1 check("comb_en", comb_out_en, 1'h0);
    suspend_active = 1'h0;
    suspend_status_out_b = 1'h1;
    cyc(8);
    rgpio_sel_gpio = 6'($random(seed));
    cyc(2);
    check("reg_off", reg_out_en, 1'h0);
    check("cpu_rst", cpu_reset_out_b, 1'h0);
    check("ratio", {cpu_int_request, cpu_nmi, ignore_numeric_error_b,
                    addr_bit20_mask_b}, bus_ratio);
    check("ratio_en", ratio_drive_en, 1'h1);
    check("strap_oe", quick_start_strap_pin_oe, 1'h1);
    check("float", strap_float, 1'h1);
    check("gpio_keep", rgpio_gpio_mode, gpio_exp);
    pci_bus_reset_b = 1'h1;
    wait_rel();
    check("rel_dly", n >= DLY + 2 && n <= DLY + 7, 1'h1);
    check("strap_cap", strap_seen, mem_addr_lines);
    check("breq_rise", breq_seen, 1'h0);
    cyc(2);
    check("strap_hold", queue_depth_strap_pin_oe, 1'h1);
    check("breq_tail", bus_request_zero_oe, 1'h0);
    cyc(3);
    check("float_off", strap_float, 1'h0);
    check("strap_off", quick_start_strap_pin_oe, 1'h0);
    check("breq_off", bus_request_zero_oe, 1'h0);
    check("ratio_off", ratio_drive_en, 1'h0);
  endtask : cold
  task automatic sleep(input logic str);
    suspend_to_ram = str;
    pos_cpu_reset_en = ~str;
    suspend_status_out_b = 1'h0;
    suspend_active = 1'h1;
    cyc(8);
    check("iso", {host_out_en, host_in_isolate}, 2'h1);
    check("cke", sdram_cke, 1'h0);
  endtask : sleep
  initial begin
    cyc(20);
    rst_b = 1'h1;
    cyc(4);
    resume_well_reset_b = 1'h1;
    repeat (3) begin
      rgpio_sel_gpio = 6'($random(seed));
      cyc(6);
      cold();
    end
    resume_well_reset_b = 1'h0;
    cyc(6);
    check("gpio_fn", rgpio_gpio_mode, 6'h0);
    resume_well_reset_b = 1'h1;
    rgpio_sel_gpio = 6'h0;
    cyc(6);
    sleep(1'h1);
    cold();
    sleep(1'h0);
    suspend_status_out_b = 1'h1;
    suspend_active = 1'h0;
    wait_rel();
    check("pos_dly", n >= DLY + 2 && n <= DLY + 7, 1'h1);
    // pci reset cut short mid-count must restart the full delay
    pci_bus_reset_b = 1'h0;
    cyc(8);
    pci_bus_reset_b = 1'h1;
    cyc(DLY / 2);
    cold();
    test_done();
  end
endmodule : testbench
